// File: dac_update_control.sv
// Device end: reset sequence, clear, busy and load update of a 32-channel DAC
// How it works
// - Reset rising edge restores input and trim registers
// - Host writes nothing during the reset sequence
// - Only the reset rising edge acts
// - Host pulses reset low at least 30 ns
// - After reset outputs sit at signal ground
// - Clear grounds outputs and ignores load strobes
// - Clear leaves all registers untouched
// - Host holds clear while changing output span
// - Each data write recalculates, busy low meanwhile
// - Writes accepted while busy, no output update
// - Busy is a shared wired line
// - Load during busy is latched, done afterwards
// - Load held low updates on busy rising
// - A/B select write holds busy low 500 ns
// - Write targets 1, 4, 8 or 32 channels
// - One shared multiplier walks channels in turn
// - Busy at most (channels+1)*600 ns plus 300 ns
// - Load copies computed A or B per select
// - Only freshly computed channels and channels with a newly written A/B select are loaded
// - Default offset 32768, default gain 65535
// - Select bit 0 picks A, 1 picks B
// - Code is input*(gain+1)/65536+offset-32768
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
module dac_update_control
	import dac_ctrl_pkg::*;
#(
	parameter int RESET_SEQ_CYCLES = RESET_SEQ_CYC
) (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Link to the host
	dac_link_if.device link,
	// Output lane observation
	input wire logic [CH_W-1:0] lane_sel,
	output logic [DATA_W-1:0] lane_code,
	output logic lane_at_ground,
	// Status
	output logic reset_seq_active,
	output logic calc_busy
);

	typedef enum logic [1:0] {ENG_IDLE, ENG_CALC, ENG_FINISH} eng_t;

	typedef struct packed {
		logic [NUM_CH-1:0][DATA_W-1:0] input_reg_a;
		logic [NUM_CH-1:0][DATA_W-1:0] input_reg_b;
		logic [NUM_CH-1:0][DATA_W-1:0] gain;
		logic [NUM_CH-1:0][DATA_W-1:0] offset;
		logic [NUM_CH-1:0][DATA_W-1:0] computed_reg_a;
		logic [NUM_CH-1:0][DATA_W-1:0] computed_reg_b;
		logic [NUM_CH-1:0][DATA_W-1:0] out_code;
		logic [NUM_CH-1:0] ab_sel;
		logic [NUM_CH-1:0] dirty;
		logic [NUM_CH-1:0] grounded;
		logic [NUM_CH-1:0] pend_a;
		logic [NUM_CH-1:0] pend_b;
		eng_t eng;
		logic [CNT_W-1:0] eng_cnt;
		logic [CH_W-1:0] cur_ch;
		logic [CNT_W-1:0] ab_cnt;
		logic [SEQ_W-1:0] seq_cnt;
		logic reset_prev;
		logic load_prev;
		logic busy_prev;
		logic load_req;
		logic [DATA_W-1:0] lane_code;
		logic lane_ground;
	} dev_state_t;

	dev_state_t state_reg;
	dev_state_t state_next;
	logic [NUM_CH-1:0] tmask;
	logic [NUM_CH-1:0] rest;
	logic busy_drive;
	logic load_fall;
	logic busy_rise;

	// Default register contents, shared by core reset and the reset pin
	function automatic dev_state_t power_on_state();
		dev_state_t d;
		d = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			d.input_reg_a[i] = INPUT_DEFAULT;
			d.input_reg_b[i] = INPUT_DEFAULT;
			d.gain[i] = GAIN_DEFAULT;
			d.offset[i] = OFFSET_DEFAULT;
			d.computed_reg_a[i] = INPUT_DEFAULT;
			d.computed_reg_b[i] = INPUT_DEFAULT;
		end
		d.grounded = '1;
		d.eng = ENG_IDLE;
		d.reset_prev = 1'b1;
		d.load_prev = 1'b1;
		d.busy_prev = 1'b1;
		d.lane_ground = 1'b1;
		return d;
	endfunction

	// Corrected code, clamped to the converter range
	function automatic logic [DATA_W-1:0] calc_code(input logic [DATA_W-1:0] x,
		input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] c);
		logic [2*DATA_W:0] prod;
		logic signed [DATA_W+2:0] sum;
		prod = 33'(x) * 33'(17'(m) + 17'h00001);
		sum = $signed({2'b00, prod[2*DATA_W:DATA_W]}) + $signed({3'b000, c})
			- $signed(CODE_MID);
		if (sum < 0) begin
			return '0;
		end else if (sum > $signed(CODE_MAX)) begin
			return '1;
		end
		return sum[DATA_W-1:0];
	endfunction

	// Channels touched by one write
	function automatic logic [NUM_CH-1:0] target_mask(input wr_target_t t,
		input logic [CH_W-1:0] ch);
		logic [NUM_CH-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			unique case (t)
				TGT_SINGLE: m[i] = (i == int'(ch));
				TGT_GROUP: m[i] = (i / GROUP_CH == int'(ch) / GROUP_CH);
				TGT_ACROSS: m[i] = (i % GROUP_CH == int'(ch) % GROUP_CH);
				TGT_ALL: m[i] = 1'b1;
			endcase
		end
		return m;
	endfunction

	// Lowest pending channel goes to the multiplier next
	function automatic logic [CH_W-1:0] first_set(input logic [NUM_CH-1:0] m);
		logic [CH_W-1:0] idx;
		idx = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (m[i]) begin
				idx = CH_W'(i);
			end
		end
		return idx;
	endfunction

	// Own busy: any pending or running calculation, or an A/B select hold
	assign busy_drive = (|(state_reg.pend_a | state_reg.pend_b))
		|| (state_reg.eng != ENG_IDLE) || (state_reg.ab_cnt != '0);
	// Open-drain: drive low or release to the pull-up
	assign link.busy_o = 1'b0;
	assign link.busy_oe = busy_drive;
	assign calc_busy = busy_drive;
	assign reset_seq_active = (state_reg.seq_cnt != '0);
	assign lane_code = state_reg.lane_code;
	assign lane_at_ground = state_reg.lane_ground;
	// Wire level, not own drive, gates loads so other devices can hold them off
	assign load_fall = !link.load_outputs_n && state_reg.load_prev;
	assign busy_rise = link.busy_n && !state_reg.busy_prev;
	assign tmask = target_mask(link.wr_target, link.wr_chan);

	// Next-state logic
	always_comb begin
		state_next = state_reg;
		rest = '0;
		state_next.reset_prev = link.reset_n;
		state_next.load_prev = link.load_outputs_n;
		state_next.busy_prev = link.busy_n;
		if (link.reset_n && !state_reg.reset_prev) begin
			// Low level alone does nothing; the release starts the sequence
			state_next = power_on_state();
			state_next.seq_cnt = SEQ_W'(RESET_SEQ_CYCLES);
		end else begin
			if (state_reg.seq_cnt != '0) begin
				state_next.seq_cnt = state_reg.seq_cnt - 1'b1;
			end
			if (state_reg.ab_cnt != '0) begin
				state_next.ab_cnt = state_reg.ab_cnt - 1'b1;
			end
			// Load handling; the clear runs before the set so a new strobe wins
			if (!link.output_clear_n) begin
				state_next.load_req = 1'b0;
			end else begin
				if (state_reg.load_req && link.busy_n) begin
					state_next.load_req = 1'b0;
					for (int i = 0; i < NUM_CH; i++) begin
						if (state_reg.dirty[i]) begin
							state_next.out_code[i] = state_reg.ab_sel[i] ?
								state_reg.computed_reg_b[i] :
								state_reg.computed_reg_a[i];
							state_next.grounded[i] = 1'b0;
							state_next.dirty[i] = 1'b0;
						end
					end
				end
				if (load_fall) begin
					state_next.load_req = 1'b1;
				end
				if (busy_rise && !link.load_outputs_n) begin
					state_next.load_req = 1'b1;
				end
			end
			// Shared multiplier, one channel per stage
			unique case (state_reg.eng)
				ENG_IDLE: begin
					if (|(state_reg.pend_a | state_reg.pend_b)) begin
						state_next.eng = ENG_CALC;
						state_next.cur_ch = first_set(state_reg.pend_a | state_reg.pend_b);
						// Idle cycle already counts towards the first stage
						state_next.eng_cnt = CNT_W'(STAGE_CYC - 2);
					end
				end
				ENG_CALC: begin
					if (state_reg.eng_cnt != '0) begin
						state_next.eng_cnt = state_reg.eng_cnt - 1'b1;
					end else begin
						if (state_reg.pend_a[state_reg.cur_ch]) begin
							state_next.computed_reg_a[state_reg.cur_ch] = calc_code(
								state_reg.input_reg_a[state_reg.cur_ch],
								state_reg.gain[state_reg.cur_ch],
								state_reg.offset[state_reg.cur_ch]);
							state_next.dirty[state_reg.cur_ch] = 1'b1;
						end
						if (state_reg.pend_b[state_reg.cur_ch]) begin
							state_next.computed_reg_b[state_reg.cur_ch] = calc_code(
								state_reg.input_reg_b[state_reg.cur_ch],
								state_reg.gain[state_reg.cur_ch],
								state_reg.offset[state_reg.cur_ch]);
							state_next.dirty[state_reg.cur_ch] = 1'b1;
						end
						state_next.pend_a[state_reg.cur_ch] = 1'b0;
						state_next.pend_b[state_reg.cur_ch] = 1'b0;
						rest = (state_reg.pend_a | state_reg.pend_b)
							& ~(NUM_CH'(1) << state_reg.cur_ch);
						if (|rest) begin
							state_next.cur_ch = first_set(rest);
							state_next.eng_cnt = CNT_W'(STAGE_CYC - 1);
						end else begin
							state_next.eng = ENG_FINISH;
							state_next.eng_cnt = CNT_W'(STAGE_CYC + TAIL_CYC - 1);
						end
					end
				end
				ENG_FINISH: begin
					if (|(state_reg.pend_a | state_reg.pend_b)) begin
						state_next.eng = ENG_CALC;
						state_next.cur_ch = first_set(state_reg.pend_a | state_reg.pend_b);
						state_next.eng_cnt = CNT_W'(STAGE_CYC - 1);
					end else if (state_reg.eng_cnt != '0) begin
						state_next.eng_cnt = state_reg.eng_cnt - 1'b1;
					end else begin
						state_next.eng = ENG_IDLE;
					end
				end
				default: state_next.eng = ENG_IDLE;
			endcase
			// Writes, also while busy; dropped during the reset sequence
			if (link.wr_valid && state_reg.seq_cnt == '0) begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (tmask[i]) begin
						unique case (link.wr_kind)
							KIND_INPUT_A: begin
								state_next.input_reg_a[i] = link.wr_data;
								state_next.pend_a[i] = 1'b1;
							end
							KIND_INPUT_B: begin
								state_next.input_reg_b[i] = link.wr_data;
								state_next.pend_b[i] = 1'b1;
							end
							KIND_GAIN: begin
								state_next.gain[i] = link.wr_data;
								state_next.pend_a[i] = 1'b1;
								state_next.pend_b[i] = 1'b1;
							end
							KIND_OFFSET: begin
								state_next.offset[i] = link.wr_data;
								state_next.pend_a[i] = 1'b1;
								state_next.pend_b[i] = 1'b1;
							end
							// Span changes act outside this block
							KIND_SPAN: state_next.ab_cnt = state_next.ab_cnt;
							// Select bits are written group-wide below, not per target
							KIND_AB_SELECT: state_next.ab_cnt = state_next.ab_cnt;
							default: state_next.ab_cnt = state_next.ab_cnt;
						endcase
					end
				end
				if (link.wr_kind == KIND_AB_SELECT) begin
					// Whole group of eight, or all 32 channels for TGT_ALL, is rewritten, toggling outputs on next load
					for (int i = 0; i < NUM_CH; i++) begin
						if (link.wr_target == TGT_ALL ||
							i / GROUP_CH == int'(link.wr_chan) / GROUP_CH) begin
							state_next.ab_sel[i] = link.wr_data[i % GROUP_CH];
							state_next.dirty[i] = 1'b1;
						end
					end
					state_next.ab_cnt = CNT_W'(AB_BUSY_CYC);
				end
			end
		end
		// Clear grounds the lane without touching any register
		state_next.lane_code = state_reg.out_code[lane_sel];
		state_next.lane_ground = !link.output_clear_n || state_reg.grounded[lane_sel];
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= power_on_state();
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

endmodule // dac_update_control

// File: dac_ctrl_pkg.sv
// Shared constants and types for the DAC update-control device and its host controller
package dac_ctrl_pkg;

	// Channel organisation
	localparam int DATA_W = 16;
	localparam int NUM_CH = 32;
	localparam int GROUP_CH = 8;
	localparam int NUM_GROUPS = 4;
	localparam int CH_W = 5;
	localparam int CNT_W = 12;
	localparam int SEQ_W = 16;

	// Timing in nanoseconds, then in ref_clk cycles
	localparam int CLK_PERIOD_NS = 8;
	localparam int STAGE_NS = 600;
	localparam int TAIL_NS = 300;
	localparam int AB_BUSY_NS = 500;
	localparam int RESET_SEQ_NS = 300000;
	localparam int RESET_PULSE_NS = 30;
	localparam int SPAN_HOLD_NS = 1000;
	// Longest times round down, least times round up
	localparam int STAGE_CYC = STAGE_NS / CLK_PERIOD_NS;
	localparam int TAIL_CYC = TAIL_NS / CLK_PERIOD_NS;
	localparam int AB_BUSY_CYC = AB_BUSY_NS / CLK_PERIOD_NS;
	localparam int RESET_SEQ_CYC = (RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SPAN_HOLD_CYC = (SPAN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register defaults of the 16-bit variant
	localparam logic [DATA_W-1:0] INPUT_DEFAULT = 16'h5554;
	localparam logic [DATA_W-1:0] GAIN_DEFAULT = 16'hFFFF;
	localparam logic [DATA_W-1:0] OFFSET_DEFAULT = 16'h8000;
	localparam logic [DATA_W+2:0] CODE_MID = 19'h08000;
	localparam logic [DATA_W+2:0] CODE_MAX = 19'h0FFFF;

	// Link write kinds and channel targeting
	typedef enum logic [2:0] {
		KIND_INPUT_A, KIND_INPUT_B, KIND_GAIN, KIND_OFFSET, KIND_AB_SELECT, KIND_SPAN
	} wr_kind_t;
	typedef enum logic [1:0] {TGT_SINGLE, TGT_GROUP, TGT_ACROSS, TGT_ALL} wr_target_t;

	// Host register map (byte addresses)
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_WRITE = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam int CTRL_LOAD_BIT = 2;
	localparam int CTRL_LOAD_HOLD_BIT = 3;
	localparam int WR_DATA_LSB = 0;
	localparam int WR_CHAN_LSB = 16;
	localparam int WR_TGT_LSB = 21;
	localparam int WR_KIND_LSB = 23;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_SEQ_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_CLEAR_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: dac_link_if.sv
// Pin-level link between the host controller and the DAC update-control device
interface dac_link_if;
	import dac_ctrl_pkg::*;

	// Control pins driven by the host
	logic reset_n;
	logic output_clear_n;
	logic load_outputs_n;
	// Register write port driven by the host
	logic wr_valid;
	wr_kind_t wr_kind;
	wr_target_t wr_target;
	logic [CH_W-1:0] wr_chan;
	logic [DATA_W-1:0] wr_data;
	// Open-drain busy line
	logic busy_o;
	logic busy_oe;
	logic busy_n;

	// Pull-up holds the line high unless the device pulls it down
	assign busy_n = busy_oe ? busy_o : 1'b1;

	modport device (
		input reset_n, output_clear_n, load_outputs_n,
		input wr_valid, wr_kind, wr_target, wr_chan, wr_data,
		output busy_o, busy_oe,
		input busy_n
	);
	modport host (
		output reset_n, output_clear_n, load_outputs_n,
		output wr_valid, wr_kind, wr_target, wr_chan, wr_data,
		input busy_n
	);
endinterface

// File: dac_host_control.sv
// Host end: AXI4-Lite register slave that drives the DAC control pins
module dac_host_control
	import dac_ctrl_pkg::*;
#(
	parameter int RESET_SEQ_CYCLES = RESET_SEQ_CYC
) (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Link to the device
	dac_link_if.host link
);

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic clear_hold;
		logic load_hold;
		logic load_go;
		logic refused;
		logic [2:0] pulse_cnt;
		logic [SEQ_W-1:0] seq_cnt;
		logic [CNT_W-1:0] span_cnt;
		logic [31:0] last_write;
		logic pin_reset_n;
		logic pin_clear_n;
		logic pin_load_n;
		logic wr_valid;
		logic [2:0] kind;
		logic [1:0] tgt;
		logic [CH_W-1:0] chan;
		logic [DATA_W-1:0] data;
	} host_state_t;

	localparam host_state_t HOST_RESET = '{pin_reset_n: 1'b1, pin_clear_n: 1'b1,
		pin_load_n: 1'b1, default: '0};

	host_state_t state_reg;
	host_state_t state_next;

	// Byte-lane mask from write strobes
	function automatic logic [31:0] strobe_mask(input logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	// Handshakes: one write and one read in flight
	assign awready = !state_reg.aw_got && !state_reg.bvalid;
	assign wready = !state_reg.w_got && !state_reg.bvalid;
	assign arready = !state_reg.rvalid;
	assign bvalid = state_reg.bvalid;
	assign bresp = state_reg.bresp;
	assign rvalid = state_reg.rvalid;
	assign rdata = state_reg.rdata;
	assign rresp = state_reg.rresp;
	assign link.reset_n = state_reg.pin_reset_n;
	assign link.output_clear_n = state_reg.pin_clear_n;
	assign link.load_outputs_n = state_reg.pin_load_n;
	assign link.wr_valid = state_reg.wr_valid;
	assign link.wr_kind = wr_kind_t'(state_reg.kind);
	assign link.wr_target = wr_target_t'(state_reg.tgt);
	assign link.wr_chan = state_reg.chan;
	assign link.wr_data = state_reg.data;

	// Next-state logic
	always_comb begin
		state_next = state_reg;
		state_next.wr_valid = 1'b0;
		state_next.load_go = 1'b0;
		// Reset pulse, then wait out the device's sequence
		if (state_reg.pulse_cnt != '0) begin
			state_next.pulse_cnt = state_reg.pulse_cnt - 1'b1;
			if (state_reg.pulse_cnt == 3'h1) begin
				state_next.seq_cnt = SEQ_W'(RESET_SEQ_CYCLES);
			end
		end else if (state_reg.seq_cnt != '0) begin
			state_next.seq_cnt = state_reg.seq_cnt - 1'b1;
		end
		if (state_reg.span_cnt != '0) begin
			state_next.span_cnt = state_reg.span_cnt - 1'b1;
		end
		if (awvalid && awready) begin
			state_next.aw_got = 1'b1;
			state_next.waddr = awaddr;
		end
		if (wvalid && wready) begin
			state_next.w_got = 1'b1;
			state_next.wdata = wdata & strobe_mask(wstrb);
		end
		if (state_reg.bvalid && bready) begin
			state_next.bvalid = 1'b0;
		end
		// Execute once both address and data are held
		if (state_next.aw_got && state_next.w_got && !state_reg.bvalid) begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			if (state_next.waddr == REG_CTRL) begin
				if (state_next.wdata[CTRL_RESET_BIT] && state_reg.pulse_cnt == '0) begin
					state_next.pulse_cnt = 3'(RESET_PULSE_CYC);
					state_next.seq_cnt = '0;
				end
				state_next.clear_hold = state_next.wdata[CTRL_CLEAR_BIT];
				// Load may be requested any time; the device defers it while busy
				state_next.load_go = state_next.wdata[CTRL_LOAD_BIT];
				state_next.load_hold = state_next.wdata[CTRL_LOAD_HOLD_BIT];
			end else if (state_next.waddr == REG_WRITE) begin
				state_next.last_write = state_next.wdata;
				if (state_reg.pulse_cnt != '0 || state_reg.seq_cnt != '0) begin
					state_next.refused = 1'b1;
				end else begin
					state_next.refused = 1'b0;
					state_next.wr_valid = 1'b1;
					state_next.data = state_next.wdata[WR_DATA_LSB +: DATA_W];
					state_next.chan = state_next.wdata[WR_CHAN_LSB +: CH_W];
					state_next.tgt = state_next.wdata[WR_TGT_LSB +: 2];
					state_next.kind = state_next.wdata[WR_KIND_LSB +: 3];
					if (state_next.kind == 3'(KIND_SPAN)) begin
						state_next.span_cnt = CNT_W'(SPAN_HOLD_CYC);
					end
				end
			end else if (state_next.waddr != REG_STATUS) begin
				state_next.bresp = RESP_SLVERR;
			end
		end
		// Reads answer one cycle after the address is taken
		if (state_reg.rvalid && rready) begin
			state_next.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = RESP_OKAY;
			state_next.rdata = '0;
			unique case (araddr)
				REG_CTRL: begin
					state_next.rdata[CTRL_CLEAR_BIT] = state_reg.clear_hold;
					state_next.rdata[CTRL_LOAD_HOLD_BIT] = state_reg.load_hold;
				end
				REG_WRITE: state_next.rdata = state_reg.last_write;
				REG_STATUS: begin
					state_next.rdata[ST_BUSY_BIT] = !link.busy_n;
					state_next.rdata[ST_SEQ_BIT] = (state_reg.seq_cnt != '0)
						|| (state_reg.pulse_cnt != '0);
					state_next.rdata[ST_REFUSED_BIT] = state_reg.refused;
					state_next.rdata[ST_CLEAR_BIT] = !state_reg.pin_clear_n;
				end
				default: state_next.rresp = RESP_SLVERR;
			endcase
		end
		// Pins follow the new state, so a span write meets clear already low
		state_next.pin_reset_n = (state_next.pulse_cnt == '0);
		state_next.pin_clear_n = !state_next.clear_hold && (state_next.span_cnt == '0);
		state_next.pin_load_n = !(state_next.load_go || state_next.load_hold);
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= HOST_RESET;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

endmodule // dac_host_control

// File: dac_update_control_asserts.sv
// Checker for the link between the DAC host end and device end
module dac_update_control_asserts
	import dac_ctrl_pkg::*;
#(
	parameter int RESET_SEQ_CYCLES = 20
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Link signals
	input wire logic reset_n,
	input wire logic output_clear_n,
	input wire logic wr_valid,
	input wire wr_kind_t wr_kind,
	input wire wr_target_t wr_target,
	input wire logic busy_o,
	input wire logic busy_oe,
	input wire logic busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Our own view of the reset sequence; one cycle of slack for edge alignment
	logic [15:0] seq_reg;
	logic prev_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seq_reg <= 16'h0;
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= reset_n;
			if (reset_n && !prev_reg) seq_reg <= 16'(RESET_SEQ_CYCLES);
			else if (seq_reg != 16'h0) seq_reg <= seq_reg - 16'h1;
		end
	end

	property p_busy_od;
		busy_oe |-> busy_o == 1'b0 && busy_n == 1'b0;
	endproperty
	a_busy_od: assert property (p_busy_od) else $error("busy line not pulled low");
	property p_calc;
		wr_valid && wr_kind inside {KIND_INPUT_A, KIND_INPUT_B, KIND_GAIN, KIND_OFFSET}
			|=> busy_oe;
	endproperty
	a_calc: assert property (p_calc) else $error("no busy after data write");
	property p_ab;
		wr_valid && wr_kind == KIND_AB_SELECT && !busy_oe |=> busy_oe[*8] ##54 busy_oe ##1 !busy_oe;
	endproperty
	a_ab: assert property (p_ab) else $error("select busy length wrong");
	property p_single;
		wr_valid && wr_kind inside {KIND_INPUT_A, KIND_INPUT_B, KIND_GAIN, KIND_OFFSET}
			&& wr_target == TGT_SINGLE && !busy_oe |=> busy_oe[*8] ##179 busy_oe ##1 !busy_oe;
	endproperty
	a_single: assert property (p_single) else $error("single busy length wrong");
	property p_rst_pulse;
		$fell(reset_n) |-> !reset_n[*4];
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");
	property p_no_wr;
		wr_valid |-> seq_reg < 16'h2;
	endproperty
	a_no_wr: assert property (p_no_wr) else $error("write during reset sequence");
	property p_span;
		wr_valid && wr_kind == KIND_SPAN |-> ##[0:1] !output_clear_n[*8];
	endproperty
	a_span: assert property (p_span) else $error("span write without clear");
	property p_rst_abort;
		$rose(reset_n) |-> ##[1:2] !busy_oe;
	endproperty
	a_rst_abort: assert property (p_rst_abort) else $error("busy after reset edge");
endmodule // dac_update_control_asserts

// File: tb_dac_update_control.sv
// Testbench joining host and device ends, driven over AXI4-Lite
module tb_dac_update_control
	import dac_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SEQ = 20;
	logic ref_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, lane_at_ground, seq_act, cbusy;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic [31:0] wdata = 32'h0, rdata, d, bc = 0, blen = 0;
	logic [1:0] bresp, rresp;
	logic [4:0] lane_sel = 5'h0;
	logic [15:0] lane_code;
	int mismatches = 0, n_tests = 0;

	dac_link_if link();
	dac_update_control #(.RESET_SEQ_CYCLES(SEQ)) u_dac_update_control (.ref_clk, .rst,
		.ce(1'b1), .link(link), .lane_sel, .lane_code, .lane_at_ground, .reset_seq_active(seq_act),
		.calc_busy(cbusy));
	dac_host_control #(.RESET_SEQ_CYCLES(SEQ)) u_dac_host_control (.ref_clk, .rst, .ce(1'b1),
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link(link));
	dac_update_control_asserts #(.RESET_SEQ_CYCLES(SEQ)) u_dac_update_control_asserts (
		.ref_clk, .rst, .reset_n(link.reset_n), .output_clear_n(link.output_clear_n),
		.wr_valid(link.wr_valid), .wr_kind(link.wr_kind), .wr_target(link.wr_target),
		.busy_o(link.busy_o), .busy_oe(link.busy_oe), .busy_n(link.busy_n));

	always #4 ref_clk = ~ref_clk;
	// Length of the last busy pulse, measured on the shared line
	always @(posedge ref_clk) if (!link.busy_n) bc <= bc + 1; else begin
		if (bc != 0) blen <= bc;
		bc <= 0;
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// Each channel is held until its own ready; bready until bvalid
	task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] e = RESP_OKAY);
		@(posedge ref_clk);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				chk("bresp", {30'h0, bresp}, {30'h0, e});
			end
		end while (bready);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				v = rdata;
			end
		end while (rready);
	endtask
	function automatic logic [31:0] lw(wr_kind_t k, wr_target_t t, logic [4:0] c, logic [15:0] v);
		return {6'h00, k, t, c, v};
	endfunction
	task automatic idle;
		repeat (3) @(posedge ref_clk);
		while (!link.busy_n) @(posedge ref_clk);
		@(posedge ref_clk);
	endtask
	task automatic lc(input logic [4:0] c, input logic [16:0] e);
		lane_sel <= c;
		repeat (3) @(posedge ref_clk);
		chk("lane", {15'h0, lane_at_ground, lane_code}, {15'h0, e});
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under 10000 cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		give_verdict;
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		lc(3, {1'b1, 16'h0});
		wr(REG_CTRL, 32'h1);
		wr(REG_WRITE, lw(KIND_INPUT_A, TGT_SINGLE, 3, 16'h1234));
		rd(REG_STATUS, d);
		chk("refused", {31'h0, d[2]}, 1);
		chk("seq_run", {31'h0, seq_act}, 1);
		do rd(REG_STATUS, d); while (d[1]);
		chk("seq_end", {31'h0, seq_act}, 0);
		wr(REG_WRITE, lw(KIND_INPUT_A, TGT_SINGLE, 3, 16'h1234));
		chk("calc_busy", {31'h0, cbusy}, 1);
		idle;
		chk("busy1", blen, 187);
		chk("calc_idle", {31'h0, cbusy}, 0);
		lc(3, {1'b1, 16'h0});
		wr(REG_CTRL, 32'h4);
		lc(3, {1'b0, 16'h1234});
		lc(4, {1'b1, 16'h0});
		wr(REG_CTRL, 32'h2);
		lc(3, {1'b1, 16'h1234});
		wr(REG_WRITE, lw(KIND_INPUT_A, TGT_SINGLE, 3, 16'h2222));
		idle;
		wr(REG_CTRL, 32'h6);
		wr(REG_CTRL, 32'h0);
		lc(3, {1'b0, 16'h1234});
		wr(REG_WRITE, lw(KIND_INPUT_B, TGT_SINGLE, 3, 16'h4444));
		wr(REG_CTRL, 32'h4);
		lc(3, {1'b0, 16'h1234});
		idle;
		lc(3, {1'b0, 16'h2222});
		wr(REG_WRITE, lw(KIND_AB_SELECT, TGT_SINGLE, 3, 16'h0008));
		idle;
		chk("busy_ab", blen, 62);
		lc(3, {1'b0, 16'h2222});
		wr(REG_CTRL, 32'h4);
		lc(3, {1'b0, 16'h4444});
		wr(REG_CTRL, 32'h8);
		wr(REG_WRITE, lw(KIND_GAIN, TGT_SINGLE, 3, 16'h7FFF));
		idle;
		lc(3, {1'b0, 16'h2222});
		wr(REG_WRITE, lw(KIND_INPUT_A, TGT_ACROSS, 3, 16'h1000));
		idle;
		chk("busy4", blen, 412);
		lc(27, {1'b0, 16'h1000});
		wr(REG_CTRL, 32'h0);
		wr(REG_WRITE, lw(KIND_SPAN, TGT_SINGLE, 0, 16'h0));
		wr(4'hC, 32'h0, RESP_SLVERR);
		wr(REG_CTRL, 32'h1);
		@(posedge ref_clk);
		chk("lane_hold", {16'h0, lane_code}, 32'h1000);
		do rd(REG_STATUS, d); while (d[1]);
		wr(REG_WRITE, lw(KIND_GAIN, TGT_SINGLE, 3, 16'hFFFF));
		idle;
		wr(REG_CTRL, 32'h4);
		lc(3, {1'b0, 16'h5554});
		give_verdict;
	end
endmodule // tb_dac_update_control
